// [common/clock_ctrl_pkg.sv]
// shared constants and types for the clock source and pll control block
// assumes a single 100 mhz model clock; real oscillators are modelled as enables
package clock_ctrl_pkg;

    // register map (i/o space offsets)
    localparam logic [5:0] pll_control_status_addr = 6'h29;
    localparam logic [5:0] oscillator_trim_addr = 6'h31;

    // pll_control_status fields
    localparam int pll_lock_pos = 0;
    localparam int pll_enable_pos = 1;
    localparam logic [7:0] pll_control_status_rst = 8'h00;
    localparam logic [7:0] oscillator_trim_rst = 8'h80;

    // fuse codes
    localparam logic [3:0] sel_ext_clock = 4'h0;
    localparam logic [3:0] sel_rc_1mhz = 4'h1;
    localparam logic [3:0] sel_rc_last = 4'h4;
    localparam logic [3:0] sel_ext_rc_last = 4'h8;
    localparam logic [3:0] sel_low_freq = 4'h9;
    localparam logic [3:0] default_clock_select = 4'h1;
    localparam logic [1:0] default_startup_time = 2'h2;
    localparam logic default_pll_clock_fuse = 1'b1;

    // pll figures
    localparam int pll_multiplier = 64;
    localparam int pll_ref_khz = 1000;
    localparam int sys_clk_mhz = 100;
    localparam int ref_div_cycles = sys_clk_mhz * 1000 / pll_ref_khz;
    localparam int lock_ref_cycles = 16;
    localparam logic [7:0] trim_lock_max = 8'h80;

    // start-up counts in source clock ticks
    localparam int startup_short = 6;
    localparam int startup_long = 16384;
    localparam int reset_delay_wdt = 4096;

    typedef enum logic [5:0] {
        src_ext_clock = 6'b000001,
        src_rc = 6'b000010,
        src_ext_rc = 6'b000100,
        src_low_freq = 6'b001000,
        src_crystal = 6'b010000,
        src_pll = 6'b100000
    } clock_source_e;

    typedef enum logic [2:0] {
        sleep_none = 3'b000,
        sleep_idle = 3'b001,
        sleep_adc_noise = 3'b010,
        sleep_power_down = 3'b011,
        sleep_standby = 3'b100
    } sleep_mode_e;

    typedef struct packed {
        logic core_en;
        logic io_en;
        logic flash_en;
        logic adc_en;
    } clock_gates_s;

    typedef struct packed {
        logic input_pin_used;
        logic output_pin_used;
    } pin_use_s;

endpackage

// [design/clock_source_and_pll_control.sv]
// clock source decode, clock domain gating and pll control registers
// assumes fuses are static after reset and the core drives the i/o port
`timescale 1ns/1ps
// How it works
// - clock select fuses plus pll fuse at one pick the source
// - pll fuse programmed with code 0001 selects pll clock mode
// - pins free for rc and pll, input only for ext clock/rc
// - pll multiplies its 1 mhz rc reference by 64; the model ticks every clk cycle instead
// - fast clock or its prescale offered to the second timer
// - pll runs only with enable bit set or pll fuse programmed
// - lock flag set once pll has locked
// - rc path and pll stop in power-down and standby
// - module clocks gated according to sleep mode
// - core clock halt stops register file and stack memory
// - io clock drives timers; async interrupts still seen when stopped
// - program memory clock follows the core clock
// - converter clock keeps running in noise reduction sleep
// - eeprom write finishes in power-down, oscillator then stays on
// - factory default is rc 1 mhz, long start-up, pll fuse unset
// - wake times start-up on source; reset adds watchdog delay
module clock_source_and_pll_control #(
    parameter int startup_cycles = clock_ctrl_pkg::startup_long,
    parameter int reset_cycles = clock_ctrl_pkg::reset_delay_wdt
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] clock_select_fuses,
    input wire logic [1:0] startup_time_fuses,
    input wire logic pll_clock_fuse,
    input wire logic [5:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire clock_ctrl_pkg::sleep_mode_e sleep_mode,
    input wire logic eeprom_write_busy,
    input wire logic wake_async,
    input wire logic [1:0] timer_fast_prescale,
    output clock_ctrl_pkg::clock_source_e clock_source,
    output clock_ctrl_pkg::pin_use_s pin_use,
    output clock_ctrl_pkg::clock_gates_s clock_gates,
    output logic rc_running,
    output logic pll_running,
    output logic fast_peripheral_tick,
    output logic timer_fast_tick,
    output logic async_wake,
    output logic core_ready
);
    logic [7:0] pll_control_status_ff;
    logic [7:0] oscillator_trim_ff;
    logic [3:0] sel_ff;
    logic pll_fuse_ff;
    logic fuses_taken_ff;
    logic [2:0] wake_sync_ff;
    logic wake_level_ff;
    logic [15:0] start_cnt_ff;
    logic [15:0] nxt_start_cnt;
    logic ready_ff;
    logic osc_kept_ff;
    logic [2:0] pre_cnt_ff;
    logic timer_tick_ff;
    logic fast_tick;
    logic locked;
    logic deep_sleep;
    logic pll_run;

    ////////////////////////////////////////////////////////////////
    // fuses caught after reset release, not under reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel_ff <= clock_ctrl_pkg::default_clock_select;
            pll_fuse_ff <= clock_ctrl_pkg::default_pll_clock_fuse;
            fuses_taken_ff <= 1'b0;
        end
        else if (!fuses_taken_ff)
        begin
            sel_ff <= clock_select_fuses;
            pll_fuse_ff <= pll_clock_fuse;
            fuses_taken_ff <= 1'b1;
        end
    end

    always_comb
    begin
        if (!pll_fuse_ff && sel_ff == clock_ctrl_pkg::sel_rc_1mhz)
            clock_source = clock_ctrl_pkg::src_pll;
        else if (sel_ff == clock_ctrl_pkg::sel_ext_clock)
            clock_source = clock_ctrl_pkg::src_ext_clock;
        else if (sel_ff <= clock_ctrl_pkg::sel_rc_last)
            clock_source = clock_ctrl_pkg::src_rc;
        else if (sel_ff <= clock_ctrl_pkg::sel_ext_rc_last)
            clock_source = clock_ctrl_pkg::src_ext_rc;
        else if (sel_ff == clock_ctrl_pkg::sel_low_freq)
            clock_source = clock_ctrl_pkg::src_low_freq;
        else
            clock_source = clock_ctrl_pkg::src_crystal;
    end

    always_comb
    begin
        case (clock_source)
            clock_ctrl_pkg::src_rc, clock_ctrl_pkg::src_pll:
                pin_use = '{input_pin_used: 1'b0, output_pin_used: 1'b0};
            clock_ctrl_pkg::src_ext_clock, clock_ctrl_pkg::src_ext_rc:
                pin_use = '{input_pin_used: 1'b1, output_pin_used: 1'b0};
            default:
                pin_use = '{input_pin_used: 1'b1, output_pin_used: 1'b1};
        endcase
    end

    ////////////////////////////////////////////////////////////////
    assign deep_sleep = (sleep_mode == clock_ctrl_pkg::sleep_power_down)
        || (sleep_mode == clock_ctrl_pkg::sleep_standby);

    // a write running at deep sleep entry keeps the oscillator on until wake;
    // full power-down is then never reached, so software should wait first
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            osc_kept_ff <= 1'b0;
        else if (!deep_sleep)
            osc_kept_ff <= eeprom_write_busy;
    end

    assign rc_running = !deep_sleep || osc_kept_ff;
    assign pll_run = (pll_control_status_ff[clock_ctrl_pkg::pll_enable_pos] || !pll_fuse_ff)
        && !deep_sleep;
    assign pll_running = pll_run;

    pll_lock_tracker #(
        .ref_div(clock_ctrl_pkg::ref_div_cycles),
        .lock_cycles(clock_ctrl_pkg::lock_ref_cycles)
    ) u_pll (
        .clk(clk),
        .rst(rst),
        .run(pll_run),
        .in_range(oscillator_trim_ff <= clock_ctrl_pkg::trim_lock_max),
        .ref_tick(),
        .fast_tick(fast_tick),
        .locked(locked)
    );

    assign fast_peripheral_tick = fast_tick;

    // divide by 1,2,4,8 for the second timer
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pre_cnt_ff <= 3'h0;
            timer_tick_ff <= 1'b0;
        end
        else
        begin
            pre_cnt_ff <= fast_tick ? pre_cnt_ff + 3'h1 : pre_cnt_ff;
            case (timer_fast_prescale)
                2'h0: timer_tick_ff <= fast_tick;
                2'h1: timer_tick_ff <= fast_tick && pre_cnt_ff[0];
                2'h2: timer_tick_ff <= fast_tick && (pre_cnt_ff[1:0] == 2'h3);
                default: timer_tick_ff <= fast_tick && (pre_cnt_ff == 3'h7);
            endcase
        end
    end
    assign timer_fast_tick = timer_tick_ff;

    ////////////////////////////////////////////////////////////////
    // start-up: reset waits long start-up plus watchdog delay, wake waits source only
    always_comb
    begin
        nxt_start_cnt = start_cnt_ff;
        if (deep_sleep)
            nxt_start_cnt = 16'(startup_cycles);
        else if (start_cnt_ff != 16'h0000)
            nxt_start_cnt = start_cnt_ff - 16'h0001;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            start_cnt_ff <= 16'(clock_ctrl_pkg::startup_long + clock_ctrl_pkg::reset_delay_wdt);
            ready_ff <= 1'b0;
        end
        else
        begin
            start_cnt_ff <= nxt_start_cnt;
            ready_ff <= (nxt_start_cnt == 16'h0000) && !deep_sleep;
        end
    end
    assign core_ready = ready_ff;

    always_comb
    begin
        clock_gates.core_en = ready_ff && (sleep_mode == clock_ctrl_pkg::sleep_none);
        clock_gates.flash_en = clock_gates.core_en;
        clock_gates.io_en = ready_ff && ((sleep_mode == clock_ctrl_pkg::sleep_none)
            || (sleep_mode == clock_ctrl_pkg::sleep_idle));
        clock_gates.adc_en = ready_ff && !deep_sleep;
    end

    // pin wake path, usable with io clock stopped; a level counts once stages agree
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wake_sync_ff <= 3'h0;
            wake_level_ff <= 1'b0;
        end
        else
        begin
            wake_sync_ff <= {wake_sync_ff[1:0], wake_async};
            if (wake_sync_ff[1] == wake_sync_ff[2])
                wake_level_ff <= wake_sync_ff[2];
        end
    end
    assign async_wake = wake_level_ff;

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pll_control_status_ff <= clock_ctrl_pkg::pll_control_status_rst;
            oscillator_trim_ff <= clock_ctrl_pkg::oscillator_trim_rst;
        end
        else
        begin
            if (io_wr && io_addr == clock_ctrl_pkg::pll_control_status_addr)
                pll_control_status_ff[clock_ctrl_pkg::pll_enable_pos] <=
                    io_wdata[clock_ctrl_pkg::pll_enable_pos];
            if (io_wr && io_addr == clock_ctrl_pkg::oscillator_trim_addr)
                oscillator_trim_ff <= io_wdata;
            pll_control_status_ff[clock_ctrl_pkg::pll_lock_pos] <= locked && pll_run;
        end
    end

    always_comb
    begin
        io_rdata = 8'h00;
        if (io_rd && io_addr == clock_ctrl_pkg::pll_control_status_addr)
            io_rdata = pll_control_status_ff;
        else if (io_rd && io_addr == clock_ctrl_pkg::oscillator_trim_addr)
            io_rdata = oscillator_trim_ff;
    end
endmodule

// [design/pll_lock_tracker.sv]
// pll model: 1 mhz reference tick, 64x output tick and lock detect
// assumes clk at 100 mhz; output ticks stand in for the 64 mhz clock
`timescale 1ns/1ps
module pll_lock_tracker #(
    parameter int ref_div = clock_ctrl_pkg::ref_div_cycles,
    parameter int lock_cycles = clock_ctrl_pkg::lock_ref_cycles
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic in_range,
    output logic ref_tick,
    output logic fast_tick,
    output logic locked
);
    logic [7:0] ref_cnt_ff;
    logic [7:0] lock_cnt_ff;
    logic ref_tick_ff;
    logic fast_tick_ff;

    assign ref_tick = ref_tick_ff;
    assign fast_tick = fast_tick_ff;
    assign locked = (lock_cnt_ff == 8'(lock_cycles));

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ref_cnt_ff <= 8'h00;
            ref_tick_ff <= 1'b0;
        end
        else if (!run)
        begin
            ref_cnt_ff <= 8'h00;
            ref_tick_ff <= 1'b0;
        end
        else
        begin
            ref_tick_ff <= (ref_cnt_ff == 8'(ref_div - 1));
            ref_cnt_ff <= (ref_cnt_ff == 8'(ref_div - 1)) ? 8'h00 : ref_cnt_ff + 8'h01;
        end
    end

    // 64x the reference is below clk rate, yet the model gives one tick every cycle while run is high
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            fast_tick_ff <= 1'b0;
        else
            fast_tick_ff <= run;
    end

    // lock after a run of in-range reference periods
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            lock_cnt_ff <= 8'h00;
        else if (!run || !in_range)
            lock_cnt_ff <= 8'h00;
        else if (ref_tick_ff && !locked)
            lock_cnt_ff <= lock_cnt_ff + 8'h01;
    end
endmodule

// [sim/clock_source_and_pll_control_props.sv]
// concurrent checks on the clock source and pll control block ports
// assumes fuses only change while rst is high
`timescale 1ns/1ps
module clock_source_and_pll_control_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] clock_select_fuses,
    input wire logic pll_clock_fuse,
    input wire logic [5:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire clock_ctrl_pkg::sleep_mode_e sleep_mode,
    input wire logic eeprom_write_busy,
    input wire logic wake_async,
    input wire clock_ctrl_pkg::clock_source_e clock_source,
    input wire clock_ctrl_pkg::pin_use_s pin_use,
    input wire clock_ctrl_pkg::clock_gates_s clock_gates,
    input wire logic rc_running,
    input wire logic pll_running,
    input wire logic fast_peripheral_tick,
    input wire logic async_wake,
    input wire logic core_ready
);
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////////////////////
// fuses are caught one edge after release, hence the ##1
property p_decode_ext;
    pll_clock_fuse && clock_select_fuses == 4'h0 ##1 1'b1
        |-> clock_source == clock_ctrl_pkg::src_ext_clock && pin_use == 2'b10;
endproperty
a_decode_ext: assert property (p_decode_ext) else $error("ext clock decode");
property p_decode_pll;
    !pll_clock_fuse && clock_select_fuses == 4'h1 ##1 1'b1
        |-> clock_source == clock_ctrl_pkg::src_pll && pin_use == 2'b00;
endproperty
a_decode_pll: assert property (p_decode_pll) else $error("pll decode");
property p_rc_pins;
    clock_source == clock_ctrl_pkg::src_rc |-> pin_use == 2'b00;
endproperty
a_rc_pins: assert property (p_rc_pins) else $error("rc pins not freed");
// no write pending in the three deep-sleep cycles; a write at entry keeps the oscillator up
property p_deep_off;
    sleep_mode < clock_ctrl_pkg::sleep_power_down
        ##1 (sleep_mode >= clock_ctrl_pkg::sleep_power_down && !eeprom_write_busy) [*3]
        |-> !rc_running && !pll_running;
endproperty
a_deep_off: assert property (p_deep_off) else $error("rc or pll on in deep sleep");
property p_write_keeps_osc;
    eeprom_write_busy && sleep_mode == clock_ctrl_pkg::sleep_none
        ##1 sleep_mode == clock_ctrl_pkg::sleep_power_down [*3]
        |-> rc_running && !pll_running;
endproperty
a_write_keeps_osc: assert property (p_write_keeps_osc) else $error("osc stopped under write");
property p_pll_start;
    io_wr && io_addr == 6'h29 && io_wdata[1] && sleep_mode == clock_ctrl_pkg::sleep_none
        |=> pll_running;
endproperty
a_pll_start: assert property (p_pll_start) else $error("pll did not start");
property p_lock_zero;
    !pll_running [*2] ##0 (io_rd && io_addr == 6'h29) |-> !io_rdata[0];
endproperty
a_lock_zero: assert property (p_lock_zero) else $error("lock flag with pll off");
property p_adc_gate;
    core_ready && $past(core_ready) && sleep_mode <= clock_ctrl_pkg::sleep_adc_noise
        |-> clock_gates.adc_en;
endproperty
a_adc_gate: assert property (p_adc_gate) else $error("adc clock halted");
property p_core_halt;
    sleep_mode != clock_ctrl_pkg::sleep_none |-> !clock_gates.core_en && !clock_gates.flash_en;
endproperty
a_core_halt: assert property (p_core_halt) else $error("core clock in sleep");
property p_fast_tick;
    pll_running [*2] |-> fast_peripheral_tick;
endproperty
a_fast_tick: assert property (p_fast_tick) else $error("fast clock missing");
property p_wake;
    wake_async [*5] |-> async_wake;
endproperty
a_wake: assert property (p_wake) else $error("async wake not seen");
c_pll_mode: cover property (clock_source == clock_ctrl_pkg::src_pll);
c_lock: cover property (io_rd && io_addr == 6'h29 && io_rdata[0]);
c_deep_eeprom: cover property (sleep_mode == clock_ctrl_pkg::sleep_power_down && eeprom_write_busy);
endmodule
bind clock_source_and_pll_control clock_source_and_pll_control_props props_i (
    .clk(clk),
    .rst(rst),
    .clock_select_fuses(clock_select_fuses),
    .pll_clock_fuse(pll_clock_fuse),
    .io_addr(io_addr),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .io_wdata(io_wdata),
    .io_rdata(io_rdata),
    .sleep_mode(sleep_mode),
    .eeprom_write_busy(eeprom_write_busy),
    .wake_async(wake_async),
    .clock_source(clock_source),
    .pin_use(pin_use),
    .clock_gates(clock_gates),
    .rc_running(rc_running),
    .pll_running(pll_running),
    .fast_peripheral_tick(fast_peripheral_tick),
    .async_wake(async_wake),
    .core_ready(core_ready)
);

// [sim/clock_source_and_pll_control_tb_top.sv]
// self-checking bench for the clock source and pll control block
// assumes the lock tracker keeps its default 100-cycle reference divide
`timescale 1ns/1ps
module clock_source_and_pll_control_tb_top;
logic clk, rst, pll_clock_fuse, io_wr, io_rd, eeprom_write_busy, fire, wake_async;
logic [3:0] clock_select_fuses;
logic [1:0] startup_time_fuses, timer_fast_prescale;
logic [5:0] io_addr;
logic [7:0] io_wdata, io_rdata, rv;
clock_ctrl_pkg::sleep_mode_e sleep_mode;
clock_ctrl_pkg::clock_source_e clock_source;
clock_ctrl_pkg::pin_use_s pin_use;
clock_ctrl_pkg::clock_gates_s clock_gates;
logic rc_running, pll_running, fast_peripheral_tick, timer_fast_tick, async_wake, core_ready;
logic [3:0] gt [5] = '{4'hf, 4'h5, 4'h1, 4'h0, 4'h0};
int error_cnt = 0;
int tests_run = 0;
int n, c;
clock_source_and_pll_control #(.startup_cycles(32)) clock_source_and_pll_control_i (
    .clk(clk),
    .rst(rst),
    .clock_select_fuses(clock_select_fuses),
    .startup_time_fuses(startup_time_fuses),
    .pll_clock_fuse(pll_clock_fuse),
    .io_addr(io_addr),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .io_wdata(io_wdata),
    .io_rdata(io_rdata),
    .sleep_mode(sleep_mode),
    .eeprom_write_busy(eeprom_write_busy),
    .wake_async(wake_async),
    .timer_fast_prescale(timer_fast_prescale),
    .clock_source(clock_source),
    .pin_use(pin_use),
    .clock_gates(clock_gates),
    .rc_running(rc_running),
    .pll_running(pll_running),
    .fast_peripheral_tick(fast_peripheral_tick),
    .timer_fast_tick(timer_fast_tick),
    .async_wake(async_wake),
    .core_ready(core_ready)
);
ext_source_model ext_source_model_i (.fire(fire), .pin(wake_async));
initial
begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
        error_cnt++;
        $display("BAD %0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #1 io_wr = 1'b0;
endtask
task automatic rd(input logic [5:0] a);
    @(posedge clk);
    #1 io_addr = a;
    io_rd = 1'b1;
    #2 rv = io_rdata;
    @(posedge clk);
    #1 io_rd = 1'b0;
endtask
task automatic boot(input logic f, input logic [3:0] code);
    rst = 1'b1;
    pll_clock_fuse = f;
    clock_select_fuses = code;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
endtask
// polls the lock flag; a bounded wait since lock takes ~16 reference ticks
task automatic wait_lock(input logic want);
    for (n = 0; n < 4000; n++)
    begin
        rd(6'h29);
        if (rv[0] === want) break;
    end
endtask
function automatic logic [7:0] exp_src(input logic [3:0] code);
    if (code == 4'h0) return 8'h06;
    if (code < 4'h5) return 8'h08;
    if (code < 4'h9) return 8'h12;
    if (code == 4'h9) return 8'h23;
    return 8'h43;
endfunction
task automatic complete_run;
    $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    // tests need about 21,000 cycles; margin covers the bounded lock polls
    #500us;
    error_cnt++;
    complete_run();
end
initial
begin
    {io_wr, io_rd, eeprom_write_busy, fire} = 4'h0;
    io_addr = 6'h00;
    io_wdata = 8'h00;
    startup_time_fuses = 2'h2;
    timer_fast_prescale = 2'h0;
    sleep_mode = clock_ctrl_pkg::sleep_none;
    for (c = 0; c < 16; c++)
    begin
        boot(1'b1, c[3:0]);
        chk({clock_source, pin_use}, exp_src(c[3:0]));
    end
    boot(1'b0, 4'h1);
    chk({clock_source, pin_use}, 8'h80);
    chk({7'h00, pll_running}, 8'h01);
    boot(1'b1, 4'h1);
    chk({7'h00, pll_running}, 8'h00);
    rd(6'h31);
    chk(rv, 8'h80);
    rd(6'h29);
    chk(rv, 8'h00);
    rd(6'h10);
    chk(rv, 8'h00);
    wr(6'h29, 8'hff);
    rd(6'h29);
    chk(rv, 8'h02);
    wait_lock(1'b1);
    chk(rv, 8'h03);
    chk({7'h00, fast_peripheral_tick}, 8'h01);
    for (int p = 0; p < 4; p++)
    begin
        timer_fast_prescale = p[1:0];
        repeat (16) @(posedge clk);
        c = 0;
        // sample off the edge so each registered tick is seen settled
        repeat (64)
        begin
            @(posedge clk);
            #1 c += int'(timer_fast_tick === 1'b1);
        end
        chk(c[7:0], 8'(64 >> p));
    end
    // trim past the lock point must drop the flag, then recover
    wr(6'h31, 8'h81);
    rd(6'h31);
    chk(rv, 8'h81);
    wait_lock(1'b0);
    chk(rv, 8'h02);
    wr(6'h31, 8'h80);
    wait_lock(1'b1);
    chk(rv, 8'h03);
    wr(6'h29, 8'h00);
    rd(6'h29);
    chk(rv, 8'h00);
    chk({7'h00, pll_running}, 8'h00);
    for (n = 0; n < 21000 && core_ready !== 1'b1; n++) @(posedge clk);
    #1 wr(6'h29, 8'h02);
    for (c = 0; c < 5; c++)
    begin
        sleep_mode = clock_ctrl_pkg::sleep_mode_e'(c[2:0]);
        repeat (3) @(posedge clk);
        #1 chk({4'h0, clock_gates}, {4'h0, gt[c]});
        if (c > 2) chk({6'h00, rc_running, pll_running}, 8'h00);
    end
    // the write must already run when power-down is entered from active
    sleep_mode = clock_ctrl_pkg::sleep_none;
    eeprom_write_busy = 1'b1;
    fire = 1'b1;
    repeat (2) @(posedge clk);
    #1 sleep_mode = clock_ctrl_pkg::sleep_power_down;
    repeat (5) @(posedge clk);
    #1 chk({7'h00, rc_running}, 8'h01);
    chk({7'h00, async_wake}, 8'h01);
    eeprom_write_busy = 1'b0;
    fire = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({7'h00, rc_running}, 8'h01);
    chk({7'h00, async_wake}, 8'h00);
    chk({7'h00, pll_running}, 8'h00);
    sleep_mode = clock_ctrl_pkg::sleep_none;
    repeat (2) @(posedge clk);
    #1 chk({7'h00, core_ready}, 8'h00);
    for (n = 0; n < 60 && core_ready !== 1'b1; n++) @(posedge clk);
    #1 chk({7'h00, core_ready}, 8'h01);
    complete_run();
end
endmodule

// [sim/ext_source_model.sv]
// external interrupt source standing beside the oscillator pins
// assumes the bench toggles fire; the pin answers with an async skew
`timescale 1ns/1ps
module ext_source_model (
    input wire logic fire,
    output logic pin
);
    // skew keeps pin edges off the clock so the synchroniser is exercised
    always @(fire) pin <= #3 fire;
    initial pin = 1'b0;
endmodule
